// ---- rtl/mhp_pkg.sv ----
// Constants for the nibble-wide host port.
// Assumes a nominal 25 MHz interface clock.
//
// Function
// - Receive-valid high only over frame nibbles
// - Flag decode errors on receive-error output
// - Management pin driven only in own turn
// - Receive-valid never together with transmit-enable
// - Carrier up after enable, down when ready
// - Carrier may stay high past packet end
// - Buffer one whole transmit packet
// - Seize carrier, gap, defer, then deliver
// - Carrier drops after receive unless busy
// - Receive beats transmit once a frame ends, bounded wait
// - Receive buffer holds frames, one packet data
// - Capture one nibble per edge while enabled
// - Receive-valid only after gap, no transmit
// - Drop receive-valid after last nibble
// - Send preamble and delimiter, then data

package mhp_pkg;

	// ------------------------------------------
	// Buffers
	// ------------------------------------------
	localparam int         MEM_DEPTH = 3072;    // Nibbles per packet
	localparam logic [11:0] MEM_FULL = 12'hc00; // Count when full

	// ------------------------------------------
	// Frame format
	// ------------------------------------------
	localparam logic [3:0]  PRE_NIB  = 4'h5;     // Preamble nibble
	localparam logic [3:0]  SFD_NIB  = 4'hd;     // Delimiter nibble
	localparam logic [12:0] PRE_LEN  = 13'h010;  // Preamble plus delimiter

	// ------------------------------------------
	// Timing on the link clock
	// ------------------------------------------
	localparam int IFG_NS  = 960;  // Interframe gap
	localparam int LINK_NS = 40;   // Link period at 25 MHz
	localparam logic [5:0] IFG_CYC = 6'((IFG_NS + LINK_NS - 1) / LINK_NS);

	// ------------------------------------------
	// Link state machine
	// ------------------------------------------
	typedef enum logic [5:0] {
		L_IDLE = 6'h01, // Carrier low
		L_TX   = 6'h02, // Capturing
		L_TXW  = 6'h04, // Waiting for buffer
		L_GAP  = 6'h08, // Carrier seized, gap
		L_RX   = 6'h10, // Delivering
		L_END  = 6'h20  // Receive wrap-up
	} mhp_lstate_t;

endpackage

// ---- rtl/mhp_port.sv ----
// Host-facing half-duplex nibble port.
// Assumes the host clocks transmit nibbles on
// the interface clock and honours carrier sense.
`timescale 1ns/100ps

module mhp_port (
	// Core clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_ce,
	// Link side
	input  wire logic       i_iface_ref_clock,
	input  wire logic       i_tx_enable_in,
	input  wire logic [3:0] i_nibble_data_lines,
	output logic      [3:0] o_nibble_data_lines,
	output logic            o_rx_valid_out,
	output logic            o_rx_decode_error_out,
	output logic            o_carrier_sense_out,
	// Management pin
	input  wire logic       i_mgmt_clock_in,
	input  wire logic       i_mgmt_data_io_in,
	output logic            o_mgmt_data_io_out,
	output logic            o_mgmt_data_io_oe,
	// Core transmit drain
	output logic      [3:0] o_tx_nib,
	output logic            o_tx_valid,
	output logic            o_tx_last,
	input  wire logic       i_tx_ready,
	// Core receive fill
	input  wire logic       i_rx_valid,
	input  wire logic [3:0] i_rx_nib,
	input  wire logic       i_rx_err,
	input  wire logic       i_rx_last,
	output logic            o_rx_ready
);
	import mhp_pkg::*;

	// ------------------------------------------
	// Storage
	// ------------------------------------------
	// Written by link, read by core
	logic [3:0] tx_mem [MEM_DEPTH];
	// Written by core, read by link; bit 4 error
	logic [4:0] rx_mem [MEM_DEPTH];

	// ------------------------------------------
	// Link-domain state
	// ------------------------------------------
	mhp_lstate_t lst_q;        // Link state
	mhp_lstate_t lst_d;        // Next state
	logic        ce_s1_q;      // Enable sync 1
	logic        ce_s2_q;      // Enable sync 2
	logic [11:0] txcnt_q;      // Nibbles taken
	logic        treq_q;       // Packet-ready toggle
	logic        tack_s1_q;    // Ack sync 1
	logic        tack_s2_q;    // Ack sync 2
	logic        rreq_s1_q;    // Request sync 1
	logic        rreq_s2_q;    // Request sync 2
	logic        rack_q;       // Delivered toggle
	logic [5:0]  gap_q;        // Gap counter
	logic [12:0] ridx_q;       // Delivery index
	logic [3:0]  rxd_q;        // Receive nibble out
	logic        dv_q;         // Receive valid out
	logic        er_q;         // Receive error out
	logic        crs_q;        // Carrier out
	logic        mdo_q;        // Management data out
	logic        mdoe_q;       // Management enable

	// ------------------------------------------
	// Core-domain state
	// ------------------------------------------
	logic        treq_s1_q;    // Request sync 1
	logic        treq_s2_q;    // Request sync 2
	logic        tack_q;       // Drained toggle
	logic [11:0] trd_q;        // Drain index
	logic [3:0]  tnib_q;       // Drain nibble
	logic        tval_q;       // Drain valid
	logic        tlast_q;      // Drain last
	logic        rreq_q;       // Fill-done toggle
	logic        rack_s1_q;    // Ack sync 1
	logic        rack_s2_q;    // Ack sync 2
	logic [11:0] rwa_q;        // Fill index
	logic [11:0] rlen_q;       // Filled length
	logic        rrdy_q;       // Fill ready out

	// ------------------------------------------
	// Link decode
	// ------------------------------------------
	// Core still owns the transmit buffer
	wire tx_busy = treq_q != tack_s2_q;
	// A filled receive packet waits
	wire rx_pend = rreq_s2_q != rack_q;
	wire ce_l    = ce_s2_q;
	wire in_idle = lst_q == L_IDLE;
	wire in_tx   = lst_q == L_TX;
	wire in_gap  = lst_q == L_GAP;
	wire in_rx   = lst_q == L_RX;
	// Nibble taken from the host this edge; no capture into a buffer the core still drains
	wire tx_take = i_tx_enable_in & (in_idle | in_tx | (in_gap & ~tx_busy));
	// A new frame restarts the count at zero
	wire [11:0] tx_wa = in_tx ? txcnt_q : 12'h000;
	wire tx_room = tx_wa != MEM_FULL;
	wire gap_done = gap_q == IFG_CYC - 6'h01;
	// Length is quasi-static while pending
	wire [12:0] r_last = {1'b0, rlen_q} + PRE_LEN - 13'h0001;
	wire rx_done = ridx_q == r_last;
	wire in_pre  = ridx_q < PRE_LEN;
	wire [12:0] r_off  = ridx_q - PRE_LEN;
	wire [4:0]  r_word = rx_mem[r_off[11:0]];
	// Preamble first, delimiter last of it
	wire [3:0] pre_nib = (ridx_q == PRE_LEN - 13'h0001) ? SFD_NIB : PRE_NIB;
	wire [3:0] r_nib = in_pre ? pre_nib : r_word[3:0];
	wire r_err = ~in_pre & r_word[4];

	// ------------------------------------------
	// Link next state
	// ------------------------------------------
	always_comb begin
		lst_d = lst_q;
		unique case (lst_q)
			L_IDLE: begin
				// Host frame wins a tie at idle
				if (i_tx_enable_in)
					lst_d = L_TX;
				else if (rx_pend)
					lst_d = L_GAP;
			end
			L_TX: begin
				// Frame ends; receive goes first
				if (!i_tx_enable_in)
					lst_d = rx_pend ? L_GAP : L_TXW;
			end
			L_TXW: begin
				// Carrier held until buffer frees
				if (rx_pend)
					lst_d = L_GAP;
				else if (!tx_busy)
					lst_d = L_IDLE;
			end
			L_GAP: begin
				// Defer to a just-raised enable, only with a free buffer
				if (i_tx_enable_in && !tx_busy)
					lst_d = L_TX;
				else if (gap_done)
					lst_d = L_RX;
			end
			L_RX: begin
				if (rx_done)
					lst_d = L_END;
			end
			L_END: begin
				// Keep carrier if more work waits
				if (rx_pend)
					lst_d = L_GAP;
				else if (tx_busy)
					lst_d = L_TXW;
				else
					lst_d = L_IDLE;
			end
		endcase
	end

	// ------------------------------------------
	// Link synchronisers
	// ------------------------------------------
	// Crossings from the core clock
	always_ff @(posedge i_iface_ref_clock or posedge i_reset) begin
		if (i_reset) begin
			ce_s1_q   <= 1'b0;
			ce_s2_q   <= 1'b0;
			tack_s1_q <= 1'b0;
			tack_s2_q <= 1'b0;
			rreq_s1_q <= 1'b0;
			rreq_s2_q <= 1'b0;
		end else begin
			ce_s1_q   <= i_ce;
			ce_s2_q   <= ce_s1_q;
			tack_s1_q <= tack_q;
			tack_s2_q <= tack_s1_q;
			rreq_s1_q <= rreq_q;
			rreq_s2_q <= rreq_s1_q;
		end
	end

	// ------------------------------------------
	// Link state and counters
	// ------------------------------------------
	always_ff @(posedge i_iface_ref_clock or posedge i_reset) begin
		if (i_reset) begin
			lst_q   <= L_IDLE;
			txcnt_q <= 12'h000;
			treq_q  <= 1'b0;
			rack_q  <= 1'b0;
			gap_q   <= 6'h00;
			ridx_q  <= 13'h0000;
		end else if (ce_l) begin
			lst_q <= lst_d;
			// One nibble per edge, saturating
			if (tx_take && tx_room)
				txcnt_q <= tx_wa + 12'h001;
			// Hand the whole packet to the core
			if (in_tx && !i_tx_enable_in)
				treq_q <= ~treq_q;
			if (in_rx && rx_done)
				rack_q <= ~rack_q;
			gap_q  <= in_gap ? gap_q + 6'h01 : 6'h00;
			ridx_q <= in_rx ? ridx_q + 13'h0001 : 13'h0000;
		end
	end

	// Transmit buffer write
	always_ff @(posedge i_iface_ref_clock) begin
		if (ce_l && tx_take && tx_room)
			tx_mem[tx_wa] <= i_nibble_data_lines;
	end

	// ------------------------------------------
	// Link outputs
	// ------------------------------------------
	// Data, valid and error lag the state by one edge; carrier tracks the next state
	always_ff @(posedge i_iface_ref_clock or posedge i_reset) begin
		if (i_reset) begin
			rxd_q  <= 4'h0;
			dv_q   <= 1'b0;
			er_q   <= 1'b0;
			crs_q  <= 1'b0;
			mdo_q  <= 1'b0;
			mdoe_q <= 1'b0;
		end else if (ce_l) begin
			crs_q <= lst_d != L_IDLE;
			dv_q  <= in_rx;
			rxd_q <= in_rx ? r_nib : 4'h0;
			er_q  <= in_rx & r_err;
			// No management turn: pin released
			mdo_q  <= 1'b0;
			mdoe_q <= 1'b0;
		end
	end

	assign o_nibble_data_lines   = rxd_q;
	assign o_rx_valid_out        = dv_q;
	assign o_rx_decode_error_out = er_q;
	assign o_carrier_sense_out   = crs_q;
	assign o_mgmt_data_io_out    = mdo_q;
	assign o_mgmt_data_io_oe     = mdoe_q;

	// ------------------------------------------
	// Core transmit drain
	// ------------------------------------------
	wire t_pend = treq_s2_q != tack_q;
	wire t_acc  = tval_q & i_tx_ready;
	// Load when output stage free; length stable
	wire t_load = t_pend & (~tval_q | i_tx_ready) & (trd_q != txcnt_q) & ~(t_acc & tlast_q);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			treq_s1_q <= 1'b0;
			treq_s2_q <= 1'b0;
			tack_q    <= 1'b0;
			trd_q     <= 12'h000;
			tnib_q    <= 4'h0;
			tval_q    <= 1'b0;
			tlast_q   <= 1'b0;
		end else if (i_ce) begin
			treq_s1_q <= treq_q;
			treq_s2_q <= treq_s1_q;
			if (t_load) begin
				tnib_q  <= tx_mem[trd_q];
				tlast_q <= trd_q + 12'h001 == txcnt_q;
				tval_q  <= 1'b1;
				trd_q   <= trd_q + 12'h001;
			end else if (t_acc) begin
				tval_q <= 1'b0;
				// Free the buffer back to the link
				if (tlast_q) begin
					tack_q <= ~tack_q;
					trd_q  <= 12'h000;
				end
			end
		end
	end

	assign o_tx_nib   = tnib_q;
	assign o_tx_valid = tval_q;
	assign o_tx_last  = tlast_q;

	// ------------------------------------------
	// Core receive fill
	// ------------------------------------------
	// One slot; stalls until delivered
	wire r_acc  = i_rx_valid & rrdy_q;
	wire r_busy = rreq_q != rack_s2_q;
	wire r_end  = i_rx_last | (rwa_q == MEM_FULL - 12'h001);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rack_s1_q <= 1'b0;
			rack_s2_q <= 1'b0;
			rreq_q    <= 1'b0;
			rwa_q     <= 12'h000;
			rlen_q    <= 12'h000;
			rrdy_q    <= 1'b0;
		end else if (i_ce) begin
			rack_s1_q <= rack_q;
			rack_s2_q <= rack_s1_q;
			rrdy_q    <= ~r_busy & ~(r_acc & r_end);
			if (r_acc) begin
				rwa_q <= r_end ? 12'h000 : rwa_q + 12'h001;
				// Publish length and toggle request on the same edge
				if (r_end) begin
					rlen_q <= rwa_q + 12'h001;
					rreq_q <= ~rreq_q;
				end
			end
		end
	end

	// Receive buffer write with error flag
	always_ff @(posedge i_clk) begin
		if (i_ce && r_acc)
			rx_mem[rwa_q] <= {i_rx_err, i_rx_nib};
	end

	assign o_rx_ready = rrdy_q;

	// ------------------------------------------
	// Checks
	// ------------------------------------------
	sequence s_preamble;
		(o_nibble_data_lines == PRE_NIB) [*8];
	endsequence

	a_half_duplex: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		!(o_rx_valid_out && i_tx_enable_in))
		else $error("valid with enable");

	a_valid_in_carrier: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		o_rx_valid_out |-> o_carrier_sense_out)
		else $error("valid without carrier");

	a_carrier_follows: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		(in_idle && i_tx_enable_in) |-> ##1 o_carrier_sense_out [*2])
		else $error("carrier did not rise");

	a_carrier_drop: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		$fell(o_carrier_sense_out) |-> $past(!tx_busy && !rx_pend))
		else $error("carrier dropped while busy");

	a_rx_gap_first: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		$rose(o_rx_valid_out) |-> $past(o_carrier_sense_out, 24))
		else $error("valid before gap");

	a_rx_preamble: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		$rose(o_rx_valid_out) |-> s_preamble)
		else $error("preamble missing");

	a_error_framed: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		o_rx_decode_error_out |-> o_rx_valid_out)
		else $error("error outside frame");

	a_idle_data_zero: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		!o_rx_valid_out |-> o_nibble_data_lines == 4'h0)
		else $error("data not zero");

	a_nibble_capture: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		(in_tx && i_tx_enable_in && tx_room) |=> txcnt_q == $past(txcnt_q) + 12'h001)
		else $error("nibble not taken");

	a_valid_end: assert property (@(posedge i_iface_ref_clock)
		disable iff (i_reset || !ce_l)
		(in_rx && rx_done) |=> ##1 !o_rx_valid_out)
		else $error("valid past last");

	a_drain_hold: assert property (@(posedge i_clk)
		disable iff (i_reset || !i_ce)
		(o_tx_valid && !i_tx_ready) |=> o_tx_valid && $stable(o_tx_nib))
		else $error("drain data dropped");

endmodule // mhp_port

// ---- sim/mhp_host_model.sv ----
// Host MAC model facing the nibble port.
// Assumes the bench makes the link clock.
`timescale 1ns/100ps

module mhp_host_model
	import mhp_pkg::*;
(
	// Link clock
	input  wire logic       i_lclk,
	// From the port
	input  wire logic       i_crs,
	input  wire logic       i_rxdv,
	input  wire logic       i_rxer,
	input  wire logic [3:0] i_rxd,
	// To the port
	output logic            o_txen,
	output logic      [3:0] o_txd
);
	logic [3:0] rx_q[$];  // Received nibbles
	logic       er_q[$];  // Error flag per nibble
	int         low_n;    // Cycles with carrier low
	int         seize_n;  // Carrier high, valid low
	int         gap_seen; // Seize time before valid
	logic       dv_q;     // Valid one cycle ago

	// ----------------------------------------
	// Receive capture
	// ----------------------------------------
	initial begin
		o_txen   = 1'b0;
		o_txd    = 4'hf;
		low_n    = 0;
		seize_n  = 0;
		gap_seen = 0;
		dv_q     = 1'b0;
	end

	// Sample on the link edge, as a MAC would
	always @(posedge i_lclk) begin
		low_n   <= i_crs ? 0 : low_n + 1;
		seize_n <= (i_crs && !i_rxdv) ? seize_n + 1 : 0;
		dv_q    <= i_rxdv;
		// Gap length seen at the rise of valid
		if (i_rxdv && !dv_q) begin
			gap_seen <= seize_n;
		end
		if (i_rxdv) begin
			rx_q.push_back(i_rxd);
			er_q.push_back(i_rxer);
		end
	end

	// ----------------------------------------
	// Transmit
	// ----------------------------------------
	// Start only after carrier low for a full gap
	// No jabber limit on carrier: waits as long as it takes
	task automatic send(input int n);
		@(posedge i_lclk);
		while (low_n < IFG_CYC) @(posedge i_lclk);
		o_txen <= 1'b1;
		for (int i = 0; i < n; i++) begin
			o_txd <= 4'(i + 7);
			@(posedge i_lclk);
		end
		// Enable drops before the edge after the last nibble
		o_txen <= 1'b0;
		o_txd  <= ~o_txd;
	endtask

endmodule // mhp_host_model

// ---- sim/tb_mhp_port.sv ----
// Self-checking bench for the nibble host port.
// Assumes the host model sits on the link side.
`timescale 1ns/100ps

module tb_mhp_port;
	import mhp_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic       i_clk, i_lclk, i_reset, i_tx_ready;
	logic       i_rx_valid, i_rx_err, i_rx_last;
	logic [3:0] i_rx_nib, o_nib, o_tx_nib, txd;
	logic       o_dv, o_er, o_crs, o_md, o_md_oe, txen;
	logic       o_tx_valid, o_tx_last, o_rx_ready, mdio;
	logic [3:0] tx_q[$];  // Drained nibbles
	logic       ls_q[$];  // Drained last flags
	int         stall_n, n_fail, samples_checked;

	// Pulled-up management wire
	assign mdio = o_md_oe ? o_md : 1'b1;

	mhp_port mhp_port_i (
		.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1),
		.i_iface_ref_clock(i_lclk), .i_tx_enable_in(txen),
		.i_nibble_data_lines(txd), .o_nibble_data_lines(o_nib),
		.o_rx_valid_out(o_dv), .o_rx_decode_error_out(o_er),
		.o_carrier_sense_out(o_crs), .i_mgmt_clock_in(1'b0), // Noncontinuous clock, no traffic
		.i_mgmt_data_io_in(mdio), .o_mgmt_data_io_out(o_md),
		.o_mgmt_data_io_oe(o_md_oe), .o_tx_nib(o_tx_nib),
		.o_tx_valid(o_tx_valid), .o_tx_last(o_tx_last),
		.i_tx_ready(i_tx_ready), .i_rx_valid(i_rx_valid),
		.i_rx_nib(i_rx_nib), .i_rx_err(i_rx_err),
		.i_rx_last(i_rx_last), .o_rx_ready(o_rx_ready)
	);

	mhp_host_model mhp_host_model_i (
		.i_lclk(i_lclk), .i_crs(o_crs), .i_rxdv(o_dv),
		.i_rxer(o_er), .i_rxd(o_nib), .o_txen(txen), .o_txd(txd)
	);

	// ----------------------------------------
	// Clocks and core drain
	// ----------------------------------------
	always #2.5 i_clk = ~i_clk;
	always #15 i_lclk = ~i_lclk; // Stand-in for the interface clock

	// Ready stalls one cycle in three
	always @(posedge i_clk) begin
		if (o_tx_valid && i_tx_ready) begin
			tx_q.push_back(o_tx_nib);
			ls_q.push_back(o_tx_last);
		end
		stall_n    <= stall_n + 1;
		i_tx_ready <= (stall_n % 3) != 0;
	end

	// Valid must never meet enable
	always @(posedge i_lclk) if (o_dv && txen) chk(1'b1, 1'b0);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [3:0] pat(input int i);
		return 4'(i * 3 + 1);
	endfunction

	// Core fill, held until ready is seen high
	task automatic fill(input int n, input int e);
		@(posedge i_clk);
		for (int i = 0; i < n; i++) begin
			i_rx_valid <= 1'b1;
			i_rx_nib   <= pat(i);
			i_rx_err   <= (i == e);
			i_rx_last  <= (i == n - 1);
			do @(posedge i_clk); while (o_rx_ready !== 1'b1);
		end
		i_rx_valid <= 1'b0;
	endtask

	task automatic chk_tx(input int n);
		for (int k = 0; k < 4000 && tx_q.size() < n; k++) @(posedge i_clk);
		chk(4'(tx_q.size()), 4'(n));
		for (int i = 0; i < n && i < tx_q.size(); i++) begin
			chk(tx_q[i], 4'(i + 7));
			chk({3'h0, ls_q[i]}, {3'h0, i == n - 1});
		end
		tx_q.delete();
		ls_q.delete();
	endtask

	// Preamble, delimiter, data, error mark at nibble e only when e is below n
	task automatic chk_rx(input int n, input int e);
		int t;
		t = 16 + n;
		for (int k = 0; k < 9000 && mhp_host_model_i.rx_q.size() < t; k++) @(posedge i_lclk);
		repeat (2) @(posedge i_lclk);
		chk(o_dv, 1'b0);
		chk(o_nib, 4'h0);
		chk(4'(mhp_host_model_i.rx_q.size() == t), 4'h1);
		for (int k = 0; k < t && k < mhp_host_model_i.rx_q.size(); k++) begin
			chk(mhp_host_model_i.rx_q[k], k < 15 ? PRE_NIB : k == 15 ? SFD_NIB : pat(k - 16));
			chk({3'h0, mhp_host_model_i.er_q[k]}, {3'h0, k == 16 + e});
		end
		chk(4'(mhp_host_model_i.gap_seen >= IFG_CYC), 4'h1);
		for (int k = 0; k < 200 && o_crs; k++) @(posedge i_lclk);
		chk(o_crs, 1'b0);
		mhp_host_model_i.rx_q.delete();
		mhp_host_model_i.er_q.delete();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		repeat (2) @(posedge i_clk);
		chk({o_crs, o_dv, o_er, o_md_oe}, 4'h0);
		chk(o_nib, 4'h0);
		chk({2'h0, o_md, mdio}, 4'h1);
	endtask

	// Carrier held past enable, dropped after drain
	task automatic t_tx();
		mhp_host_model_i.send(8);
		chk(o_crs, 1'b1);
		chk_tx(8);
		for (int k = 0; k < 200 && o_crs; k++) @(posedge i_lclk);
		chk(o_crs, 1'b0);
	endtask

	// Receive with an error, then one without
	task automatic t_rx();
		fill(6, 3);
		// One slot: further fill held off until delivered
		@(posedge i_clk);
		chk({3'h0, o_rx_ready}, 4'h0);
		chk_rx(6, 3);
		fill(1, 4);
		chk_rx(1, 4);
	endtask

	// Receive arrives while the host transmits
	task automatic t_mix();
		fork
			mhp_host_model_i.send(6);
			begin
				wait (txen);
				fill(3, 9);
			end
		join
		chk_tx(6);
		chk_rx(3, 9);
	endtask

	task automatic wrap_up();
		$display("checked=%0d failed=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		{i_clk, i_lclk, i_tx_ready, i_rx_valid, i_rx_err, i_rx_last} = 6'h0;
		i_rx_nib        = 4'h0;
		stall_n         = 0;
		n_fail          = 0;
		samples_checked = 0;
		i_reset = 1'b1;
		// Held over four link cycles so both domains settle
		repeat (4) @(posedge i_lclk);
		@(posedge i_clk);
		i_reset <= 1'b0;
		t_reset();
		t_tx();
		t_rx();
		t_mix();
		wrap_up();
	end

	// Whole run needs well under 20 us
	initial begin
		#100000;
		n_fail++;
		wrap_up();
	end

endmodule // tb_mhp_port
